// ### verif/branch_break_call_exec_test.sv
module branch_break_call_exec_test;
   timeunit 1ns;
   timeprecision 1ns;
   import branch_exec_pkg::*;

   logic        clk_sys = 1'b0;
   logic        srst    = 1'b1;
   logic        issue   = 1'b0;
   logic [23:0] word    = 24'h0;
   logic [31:0] pc      = 32'h0;
   logic        irq;
   instr_req_t  instr_req;
   exec_rsp_t   exec_rsp;
   apb_req_t    apb_req = '0;
   apb_rsp_t    apb_rsp;
   exec_rsp_t   r;
   logic [31:0] d;
   logic        e;
   int          error_cnt   = 0;
   int          check_count = 0;

   localparam logic [23:0] BRK_W = {8'h00, 4'h4, 4'ha, 4'h5, 4'h0};
   localparam logic [23:0] BRK_N = {8'h00, 4'hf, 4'h3, 4'h2, 4'hd};
   localparam logic [23:0] BNZ_N = {8'h00, 4'hf, 4'h4, 2'b11, 2'b11, 4'hc};

   always #25 clk_sys = ~clk_sys;

   branch_break_call_exec i_branch_break_call_exec (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .instr_req (instr_req),
      .exec_rsp  (exec_rsp),
      .apb_req   (apb_req),
      .apb_rsp   (apb_rsp),
      .irq       (irq)
   );

   core_side_model i_core_side_model (
      .clk_sys   (clk_sys),
      .issue     (issue),
      .word      (word),
      .pc        (pc),
      .instr_req (instr_req),
      .exec_rsp  (exec_rsp)
   );

   task chk(input logic [31:0] g, input logic [31:0] x);
      check_count++;
      if (g !== x) begin
         error_cnt++;
         $display("wrong value at %0t: got %h, expected %h", $time, g, x);
      end
   endtask : chk

   // one apb transfer; only the watchdog ends a wait for pready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      apb_req <= '{1'b1, 1'b0, w, a, wd};
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (apb_rsp.pready !== 1'b1);
      d = apb_rsp.prdata;
      e = apb_rsp.pslverr;
      apb_req <= '0;
   endtask : apb

   task rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(d, x);
   endtask : rd

   // issue one word; the answer is registered at the taking edge and read 1 ns later
   task run(input logic [23:0] w, input logic [31:0] p, input logic [31:0] npc);
      @(posedge clk_sys);
      issue <= 1'b1;
      word  <= w;
      pc    <= p;
      @(posedge clk_sys);
      issue <= 1'b0;
      #1;
      r = exec_rsp;
      chk(r.valid, 32'h1);
      chk(r.next_pc, npc);
   endtask : run

   task t_reset;
      rd(OFS_CTRL, 32'h67);
      rd(OFS_PSTATE, 32'h0);
      rd(OFS_DVEC, 32'h0);
      rd(OFS_IRQ_MSK, 32'h0);
   endtask : t_reset

   task t_bnz;
      i_core_side_model.set_areg(3, 32'h10);
      run({12'h800, 4'h3, 4'h5, 4'h6}, 32'h1000, 32'h0804);
      chk(r.taken, 32'h1);
      chk(r.hit, 32'h1);
      run({12'h7ff, 4'h3, 4'h5, 4'h6}, 32'h1000, 32'h1803);
      i_core_side_model.set_areg(3, 32'h0);
      run({12'h7ff, 4'h3, 4'h5, 4'h6}, 32'h1000, 32'h1003);
      chk(r.taken, 32'h0);
      i_core_side_model.set_areg(4, 32'h1);
      run(BNZ_N, 32'h2000, 32'h2043);
      i_core_side_model.set_areg(4, 32'h0);
      run(BNZ_N, 32'h2000, 32'h2002);
      apb(1'b1, OFS_CTRL, 32'h66);
      i_core_side_model.set_areg(4, 32'h1);
      run(BNZ_N, 32'h2000, 32'h2003);
      chk(r.hit, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h67);
   endtask : t_bnz

   task t_mask_bool;
      i_core_side_model.set_areg(5, 32'hf0f0_0000);
      i_core_side_model.set_areg(6, 32'h0f0f_ffff);
      run({8'h80, 4'h0, 4'h5, 4'h6, 4'h7}, 32'h3000, 32'h2f84);
      i_core_side_model.set_areg(6, 32'h0010_0000);
      run({8'h80, 4'h0, 4'h5, 4'h6, 4'h7}, 32'h3000, 32'h3003);
      i_core_side_model.set_flag(2, 1'b1);
      run({8'h7f, 4'h1, 4'h2, 4'h7, 4'h6}, 32'h4000, 32'h4083);
      chk(r.hit, 32'h1);
      i_core_side_model.set_flag(2, 1'b0);
      run({8'h7f, 4'h1, 4'h2, 4'h7, 4'h6}, 32'h4000, 32'h4003);
      i_core_side_model.set_flag(2, 1'b1);
      apb(1'b1, OFS_CTRL, 32'h63);
      run({8'h7f, 4'h1, 4'h2, 4'h7, 4'h6}, 32'h4000, 32'h4003);
      chk(r.hit, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h67);
   endtask : t_mask_bool

   task t_break;
      apb(1'b0, OFS_IRQ_ST, 32'h0);
      apb(1'b1, OFS_IRQ_MSK, 32'h1);
      apb(1'b1, OFS_DVEC, 32'h7000);
      apb(1'b1, OFS_PSTATE, 32'h3);
      run(BRK_W, 32'h6000, 32'h7000);
      chk(r.dbg_exc, 32'h1);
      rd(OFS_SAVED_PC, 32'h6000);
      rd(OFS_SAVED_ST, 32'h3);
      rd(OFS_DREASON, 32'h08);
      rd(OFS_PSTATE, 32'h16);
      #1 chk(irq, 32'h1);
      rd(OFS_IRQ_ST, 32'h1);
      repeat (2) @(posedge clk_sys);
      #1 chk(irq, 32'h0);
      run(BRK_W, 32'h6100, 32'h6103);
      chk(r.dbg_exc, 32'h0);
      run(BRK_N, 32'h6200, 32'h6202);
      rd(OFS_SAVED_PC, 32'h6000);
      apb(1'b1, OFS_PSTATE, 32'h0);
      run(BRK_N, 32'h6300, 32'h7000);
      chk(r.dbg_exc, 32'h1);
      rd(OFS_DREASON, 32'h10);
      rd(OFS_SAVED_PC, 32'h6300);
      apb(1'b1, OFS_PSTATE, 32'h0);
      run({8'h00, 4'h4, 4'hf, 4'hf, 4'h0}, 32'h6400, 32'h7000);
      rd(OFS_DREASON, 32'h08);
   endtask : t_break

   task t_call;
      apb(1'b0, OFS_IRQ_ST, 32'h0);
      run({18'h3ffff, 6'h05}, 32'h5003, 32'h5000);
      chk(r.link_we, 32'h1);
      chk(r.link_data, 32'h5006);
      run({18'h1ffff, 6'h05}, 32'h5001, 32'h85000);
      @(posedge clk_sys);
      #1 chk(i_core_side_model.areg[0], 32'h5004);
      chk(irq, 32'h0);
      rd(OFS_IRQ_ST, 32'h2);
      apb(1'b1, 12'h020, 32'hffff_ffff);
      chk(e, 32'h1);
      rd(12'h020, 32'h0);
      chk(e, 32'h1);
   endtask : t_call

   task test_done;
      $display("checks %0d, errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done

   initial begin
      repeat (12) @(posedge clk_sys);
      srst <= 1'b0;
      t_reset();
      t_bnz();
      t_mask_bool();
      t_break();
      t_call();
      test_done();
   end

   // the sequence needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      test_done();
   end
endmodule : branch_break_call_exec_test

// ### verif/core_side_model.sv
module core_side_model (
   // system
   input  wire logic                        clk_sys,
   // issue side
   input  wire logic                        issue,
   input  wire logic [23:0]                 word,
   input  wire logic [31:0]                 pc,
   // design side
   output branch_exec_pkg::instr_req_t      instr_req,
   input  wire branch_exec_pkg::exec_rsp_t  exec_rsp
);
   timeunit 1ns;
   timeprecision 1ns;
   import branch_exec_pkg::*;

   logic [31:0] areg [16];
   logic        flag [16];

   // operand lanes follow the s and t fields of whatever word is issued
   always_comb begin
      instr_req.valid  = issue;
      instr_req.word   = word;
      instr_req.pc     = pc;
      instr_req.areg_s = areg[word[11:8]];
      instr_req.areg_t = areg[word[7:4]];
      instr_req.flag_s = flag[word[11:8]];
   end

   always @(posedge clk_sys) begin
      if (exec_rsp.valid === 1'b1 && exec_rsp.link_we === 1'b1) begin
         areg[0] <= exec_rsp.link_data;
      end
   end

   task set_areg(input int i, input logic [31:0] v);
      areg[i] = v;
   endtask : set_areg

   task set_flag(input int i, input logic v);
      flag[i] = v;
   endtask : set_flag

   initial begin
      for (int i = 0; i < 16; i++) begin
         areg[i] = 32'h0;
         flag[i] = 1'b0;
      end
   end
endmodule : core_side_model

// ### verilog/branch_break_call_exec.sv
module branch_break_call_exec (
   // system
   input  wire logic                        clk_sys,
   input  wire logic                        srst,
   // instruction request and answer
   input  wire branch_exec_pkg::instr_req_t instr_req,
   output branch_exec_pkg::exec_rsp_t       exec_rsp,
   // register bus
   input  wire branch_exec_pkg::apb_req_t   apb_req,
   output branch_exec_pkg::apb_rsp_t        apb_rsp,
   // interrupt
   output logic                             irq
);
   import branch_exec_pkg::*;

   exec_rsp_t           rsp_reg, rsp_next;
   apb_rsp_t            bus_reg, bus_next;
   logic [31:0]         ctrl_reg, ctrl_next;
   logic [PSTATE_W-1:0] pstate_reg, pstate_next;
   logic [31:0]         dvec_reg, dvec_next;
   logic [31:0]         saved_pc_reg, saved_pc_next;
   logic [PSTATE_W-1:0] saved_st_reg, saved_st_next;
   logic [5:0]          reason_reg, reason_next;
   logic [IRQ_W-1:0]    irq_st_reg, irq_st_next;
   logic [IRQ_W-1:0]    irq_msk_reg, irq_msk_next;
   logic                irq_reg, irq_next;

   op_kind_t         op;
   logic [23:0]      w;
   logic             density_en, debug_en, bool_en;
   logic [LVL_W-1:0] dlvl, cur_lvl;
   logic [31:0]      add_base, add_off, target;
   logic [31:0]      off12, off8, off6, off18;
   logic             brk_go;
   logic             setup, access;

   assign w          = instr_req.word;
   assign density_en = ctrl_reg[CTRL_DENSITY_BIT];
   assign debug_en   = ctrl_reg[CTRL_DEBUG_BIT];
   assign bool_en    = ctrl_reg[CTRL_BOOL_BIT];
   assign dlvl       = ctrl_reg[CTRL_DLVL_LSB +: LVL_W];
   assign cur_lvl    = pstate_reg[PSTATE_LVL_LSB +: LVL_W];
   assign off12      = {{20{w[23]}}, w[23:12]};
   assign off8       = {{24{w[23]}}, w[23:16]};
   assign off6       = {26'h0, w[5:4], w[15:12]};
   assign off18      = {{12{w[23]}}, w[23:6], 2'b00};

   // decode
   always_comb begin
      op = OPK_NONE;
      if (w[3:0] == OP0_BNZ_W && w[5:4] == N_BNZ_W && w[7:6] == M_BNZ_W) begin
         op = OPK_BNZ_W;
      end else if (w[3:0] == OP0_BNZ_N && w[7:6] == T_BNZ_N && density_en) begin
         op = OPK_BNZ_N;
      end else if (w[3:0] == OP0_MASK_CLR && w[15:12] == R_MASK_CLR) begin
         op = OPK_MASK_CLR;
      end else if (w[3:0] == OP0_BOOL_T && w[7:4] == T_BOOL_T && w[15:12] == R_BOOL_T && bool_en) begin
         op = OPK_BOOL_T;
      end else if (w[5:0] == OP_PCALL) begin
         op = OPK_PCALL;
      end else if (w[3:0] == OP0_BRK_W && w[15:12] == R_BRK_W && w[23:16] == OP12_BRK_W && debug_en) begin
         // s and t fields not compared
         op = OPK_BRK_W;
      end else if (w[3:0] == OP0_BRK_N && w[15:12] == R_BRK_N && w[7:4] == T_BRK_N && debug_en && density_en) begin
         op = OPK_BRK_N;
      end
   end

   // target operands, one shared adder
   always_comb begin
      add_base = instr_req.pc;
      add_off  = off8;
      case (op)
         OPK_BNZ_W: begin
            add_off = off12;
         end
         OPK_BNZ_N: begin
            add_off = off6;
         end
         OPK_PCALL: begin
            add_base = {instr_req.pc[31:2], 2'b00};
            add_off  = off18;
         end
         default: begin
            add_off = off8;
         end
      endcase
   end

   target_adder i_target_adder (
      .base   (add_base),
      .offset (add_off),
      .target (target)
   );

   assign brk_go = (op == OPK_BRK_W || op == OPK_BRK_N) && (cur_lvl < dlvl);
   assign setup  = apb_req.psel && !apb_req.penable;
   assign access = apb_req.psel && apb_req.penable && bus_reg.pready;

   // next state
   always_comb begin
      rsp_next         = '0;
      rsp_next.valid   = instr_req.valid;
      rsp_next.next_pc = instr_req.pc + ((w[3] && density_en) ? LEN_NARROW : LEN_WIDE);
      ctrl_next        = ctrl_reg;
      pstate_next      = pstate_reg;
      dvec_next        = dvec_reg;
      saved_pc_next    = saved_pc_reg;
      saved_st_next    = saved_st_reg;
      reason_next      = reason_reg;
      irq_msk_next     = irq_msk_reg;
      irq_st_next      = irq_st_reg;
      bus_next         = '0;

      // bus writes at the access edge, read-clear only of the bits returned
      if (access && apb_req.pwrite) begin
         if (apb_req.paddr == OFS_CTRL) begin
            ctrl_next = apb_req.pwdata;
         end else if (apb_req.paddr == OFS_PSTATE) begin
            pstate_next = apb_req.pwdata[PSTATE_W-1:0];
         end else if (apb_req.paddr == OFS_DVEC) begin
            dvec_next = apb_req.pwdata;
         end else if (apb_req.paddr == OFS_IRQ_MSK) begin
            irq_msk_next = apb_req.pwdata[IRQ_W-1:0];
         end
      end
      if (access && !apb_req.pwrite && apb_req.paddr == OFS_IRQ_ST) begin
         irq_st_next = irq_st_reg & ~bus_reg.prdata[IRQ_W-1:0];
      end

      if (instr_req.valid) begin
         rsp_next.hit = (op != OPK_NONE);
         case (op)
            OPK_BNZ_W, OPK_BNZ_N: begin
               rsp_next.taken = (instr_req.areg_s != 32'h0);
            end
            OPK_MASK_CLR: begin
               rsp_next.taken = ((instr_req.areg_s & instr_req.areg_t) == 32'h0);
            end
            OPK_BOOL_T: begin
               rsp_next.taken = instr_req.flag_s;
            end
            OPK_PCALL: begin
               // return address only, no window change
               rsp_next.taken     = 1'b1;
               rsp_next.link_we   = 1'b1;
               rsp_next.link_data = instr_req.pc + LEN_WIDE;
            end
            default: begin
               rsp_next.taken = 1'b0;
            end
         endcase
         if (rsp_next.taken) begin
            rsp_next.next_pc = target;
         end
         if (brk_go) begin
            saved_pc_next = instr_req.pc;
            saved_st_next = pstate_reg;
            reason_next = (op == OPK_BRK_W) ? REASON_BRK_W : REASON_BRK_N;
            // vector and state update, hardware wins over a bus write
            rsp_next.dbg_exc  = 1'b1;
            rsp_next.next_pc  = dvec_reg;
            pstate_next                          = pstate_reg;
            pstate_next[PSTATE_XMODE_BIT]        = 1'b1;
            pstate_next[PSTATE_LVL_LSB +: LVL_W] = dlvl;
         end
      end

      // set wins over the read-clear
      irq_st_next[IRQ_DBG_BIT]   = irq_st_next[IRQ_DBG_BIT] | rsp_next.dbg_exc;
      irq_st_next[IRQ_CALL_BIT]  = irq_st_next[IRQ_CALL_BIT] | rsp_next.link_we;
      irq_st_next[IRQ_UNDEF_BIT] = irq_st_next[IRQ_UNDEF_BIT] | (instr_req.valid && op == OPK_NONE);
      irq_next = |(irq_st_next & irq_msk_next);

      // read data is caught in setup so pready can stand in the first access cycle
      if (setup) begin
         bus_next.pready = 1'b1;
         if (apb_req.paddr == OFS_CTRL) begin
            bus_next.prdata = ctrl_reg;
         end else if (apb_req.paddr == OFS_PSTATE) begin
            bus_next.prdata = {27'h0, pstate_reg};
         end else if (apb_req.paddr == OFS_DVEC) begin
            bus_next.prdata = dvec_reg;
         end else if (apb_req.paddr == OFS_SAVED_PC) begin
            bus_next.prdata = saved_pc_reg;
         end else if (apb_req.paddr == OFS_SAVED_ST) begin
            bus_next.prdata = {27'h0, saved_st_reg};
         end else if (apb_req.paddr == OFS_DREASON) begin
            bus_next.prdata = {26'h0, reason_reg};
         end else if (apb_req.paddr == OFS_IRQ_ST) begin
            bus_next.prdata = {29'h0, irq_st_reg};
         end else if (apb_req.paddr == OFS_IRQ_MSK) begin
            bus_next.prdata = {29'h0, irq_msk_reg};
         end else begin
            bus_next.pslverr = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rsp_reg      <= '0;
         bus_reg      <= '0;
         ctrl_reg     <= CTRL_RESET;
         pstate_reg   <= PSTATE_RESET;
         dvec_reg     <= DVEC_RESET;
         saved_pc_reg <= SAVED_PC_RESET;
         saved_st_reg <= PSTATE_RESET;
         reason_reg   <= REASON_RESET;
         irq_st_reg   <= '0;
         irq_msk_reg  <= MSK_RESET;
         irq_reg      <= 1'b0;
      end else begin
         rsp_reg      <= rsp_next;
         bus_reg      <= bus_next;
         ctrl_reg     <= ctrl_next;
         pstate_reg   <= pstate_next;
         dvec_reg     <= dvec_next;
         saved_pc_reg <= saved_pc_next;
         saved_st_reg <= saved_st_next;
         reason_reg   <= reason_next;
         irq_st_reg   <= irq_st_next;
         irq_msk_reg  <= irq_msk_next;
         irq_reg      <= irq_next;
      end
   end

   assign exec_rsp = rsp_reg;
   assign apb_rsp  = bus_reg;
   assign irq      = irq_reg;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);

   a_wide_nz_target: assert property (
      instr_req.valid && op == OPK_BNZ_W && instr_req.areg_s != 32'h0
      |=> exec_rsp.taken && exec_rsp.next_pc == $past(instr_req.pc) + $past(off12) + 32'h4)
      else $error("wide nonzero branch target wrong");

   a_narrow_nz_fwd: assert property (
      instr_req.valid && op == OPK_BNZ_N
      |=> exec_rsp.next_pc == ($past(instr_req.areg_s) != 32'h0 ?
          $past(instr_req.pc) + {26'h0, $past(w[5:4]), $past(w[15:12])} + 32'h4 : $past(instr_req.pc) + 32'h2))
      else $error("narrow nonzero branch target wrong");

   a_narrow_gated: assert property (
      instr_req.valid && w[3:0] == OP0_BNZ_N && w[7:6] == T_BNZ_N && !density_en |=> !exec_rsp.hit)
      else $error("narrow branch decoded without density option");

   a_mask_clear: assert property (
      instr_req.valid && op == OPK_MASK_CLR
      |=> exec_rsp.taken == (($past(instr_req.areg_s) & $past(instr_req.areg_t)) == 32'h0))
      else $error("mask branch condition wrong");

   a_break_save: assert property (
      instr_req.valid && brk_go |=> saved_pc_reg == $past(instr_req.pc) && saved_st_reg == $past(pstate_reg))
      else $error("break did not save pc and state");

   a_break_reason: assert property (
      instr_req.valid && brk_go && op == OPK_BRK_W |=> reason_reg == 6'h08 && irq_st_reg[IRQ_DBG_BIT])
      else $error("wide break reason wrong");

   a_break_vector: assert property (
      instr_req.valid && brk_go
      |=> exec_rsp.next_pc == $past(dvec_reg) && pstate_reg[PSTATE_XMODE_BIT]
          && pstate_reg[PSTATE_LVL_LSB +: LVL_W] == $past(dlvl))
      else $error("break vector or state wrong");

   a_break_noop: assert property (
      instr_req.valid && (op == OPK_BRK_W || op == OPK_BRK_N) && cur_lvl >= dlvl
      |=> !exec_rsp.dbg_exc && saved_pc_reg == $past(saved_pc_reg) && reason_reg == $past(reason_reg))
      else $error("break acted at or above debug level");

   a_narrow_reason: assert property (
      instr_req.valid && brk_go && op == OPK_BRK_N |=> reason_reg == 6'h10)
      else $error("narrow break reason wrong");

   a_bool_true: assert property (
      instr_req.valid && op == OPK_BOOL_T |=> exec_rsp.taken == $past(instr_req.flag_s))
      else $error("bool branch condition wrong");

   a_call_return: assert property (
      instr_req.valid && op == OPK_PCALL |=> exec_rsp.link_we && exec_rsp.link_data == $past(instr_req.pc) + 32'h3)
      else $error("call return address wrong");

   a_call_target: assert property (
      instr_req.valid && op == OPK_PCALL |=> exec_rsp.next_pc[1:0] == 2'b00 && exec_rsp.next_pc ==
      {$past(instr_req.pc[31:2]), 2'b00} + $past(off18) + 32'h4)
      else $error("call target wrong");

   c_call:      cover property (instr_req.valid && op == OPK_PCALL ##1 exec_rsp.link_we);
   c_break:     cover property (instr_req.valid && brk_go ##1 exec_rsp.dbg_exc);
   c_narrow:    cover property (instr_req.valid && op == OPK_BNZ_N && instr_req.areg_s != 32'h0);
   c_break_nop: cover property (instr_req.valid && op == OPK_BRK_W && !brk_go);

endmodule : branch_break_call_exec

// ### verilog/branch_exec_pkg.sv
package branch_exec_pkg;

   // instruction side carriers
   typedef struct packed {
      logic        valid;
      logic [23:0] word;
      logic [31:0] pc;
      logic [31:0] areg_s;
      logic [31:0] areg_t;
      logic        flag_s;
   } instr_req_t;

   typedef struct packed {
      logic        valid;
      logic        hit;
      logic        taken;
      logic        dbg_exc;
      logic [31:0] next_pc;
      logic        link_we;
      logic [31:0] link_data;
   } exec_rsp_t;

   // apb carriers
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_t;

   typedef enum {
      OPK_NONE,
      OPK_BNZ_W,
      OPK_BNZ_N,
      OPK_MASK_CLR,
      OPK_BOOL_T,
      OPK_PCALL,
      OPK_BRK_W,
      OPK_BRK_N
   } op_kind_t;

   // register byte offsets
   localparam logic [11:0] OFS_CTRL     = 12'h000;
   localparam logic [11:0] OFS_PSTATE   = 12'h004;
   localparam logic [11:0] OFS_DVEC     = 12'h008;
   localparam logic [11:0] OFS_SAVED_PC = 12'h00c;
   localparam logic [11:0] OFS_SAVED_ST = 12'h010;
   localparam logic [11:0] OFS_DREASON  = 12'h014;
   localparam logic [11:0] OFS_IRQ_ST   = 12'h018;
   localparam logic [11:0] OFS_IRQ_MSK  = 12'h01c;

   // control fields
   localparam int CTRL_DENSITY_BIT = 0;
   localparam int CTRL_DEBUG_BIT   = 1;
   localparam int CTRL_BOOL_BIT    = 2;
   localparam int CTRL_DLVL_LSB    = 4;
   localparam int LVL_W            = 4;

   // processor state fields
   localparam int PSTATE_LVL_LSB   = 0;
   localparam int PSTATE_XMODE_BIT = 4;
   localparam int PSTATE_W         = 5;

   // interrupt status bits
   localparam int IRQ_DBG_BIT   = 0;
   localparam int IRQ_CALL_BIT  = 1;
   localparam int IRQ_UNDEF_BIT = 2;
   localparam int IRQ_W         = 3;

   // reset values
   localparam logic [31:0]         CTRL_RESET     = 32'h0000_0067;
   localparam logic [PSTATE_W-1:0] PSTATE_RESET   = 5'h00;
   localparam logic [31:0]         DVEC_RESET     = 32'h0000_0000;
   localparam logic [IRQ_W-1:0]    MSK_RESET      = 3'h0;
   localparam logic [31:0]         SAVED_PC_RESET = 32'h0000_0000;
   localparam logic [5:0]          REASON_RESET   = 6'h00;

   // debug reason codes
   localparam logic [5:0] REASON_BRK_W = 6'h08;
   localparam logic [5:0] REASON_BRK_N = 6'h10;

   // pc arithmetic
   localparam logic [31:0] BRANCH_BIAS = 32'h0000_0004;
   localparam logic [31:0] LEN_WIDE    = 32'h0000_0003;
   localparam logic [31:0] LEN_NARROW  = 32'h0000_0002;

   // opcode fields
   localparam logic [3:0] OP0_BNZ_W   = 4'h6;
   localparam logic [1:0] N_BNZ_W     = 2'h1;
   localparam logic [1:0] M_BNZ_W     = 2'h1;
   localparam logic [3:0] OP0_BNZ_N   = 4'hc;
   localparam logic [1:0] T_BNZ_N     = 2'h3;
   localparam logic [3:0] OP0_MASK_CLR = 4'h7;
   localparam logic [3:0] R_MASK_CLR   = 4'h0;
   localparam logic [3:0] OP0_BOOL_T   = 4'h6;
   localparam logic [3:0] T_BOOL_T     = 4'h7;
   localparam logic [3:0] R_BOOL_T     = 4'h1;
   localparam logic [5:0] OP_PCALL     = 6'h05;
   localparam logic [3:0] OP0_BRK_W   = 4'h0;
   localparam logic [3:0] R_BRK_W     = 4'h4;
   localparam logic [7:0] OP12_BRK_W  = 8'h00;
   localparam logic [3:0] OP0_BRK_N   = 4'hd;
   localparam logic [3:0] R_BRK_N     = 4'hf;
   localparam logic [3:0] T_BRK_N     = 4'h2;

endpackage : branch_exec_pkg

// ### verilog/target_adder.sv
module target_adder (
   // operands
   input  wire logic [31:0] base,
   input  wire logic [31:0] offset,
   // result
   output logic      [31:0] target
);
   import branch_exec_pkg::*;

   // every target in this group is base plus offset plus four
   assign target = base + offset + BRANCH_BIAS;

endmodule : target_adder
